// [hw/rtk_core.v]
// Timekeeping core: double-buffered BCD clock registers and oscillator control
// Function
// - Clock registers live at their own addresses 0x00 to 0x0F only.
// - User registers are a buffered copy; counting runs on undisturbed.
// - Clock register contents are BCD.
// - Counts seconds up to year 9999 with weekday, months, leap years.
// - Eight clock registers set and read the time.
// - Reserved register bits read back as zero.
// - Read bit set freezes user registers; internal counting continues.
// - Freeze holds until read bit cleared; then registers refresh promptly.
// - Write bit set freezes updates and accepts new time from host.
// - Last written time is kept as nonvolatile base time.
// - Clearing write bit copies written values into counters, then resumes.
// - Invalid BCD nibbles count up to F, wrap to 0, then continue.
// - Below switchover threshold the clock keeps running on backup supply.
// - Oscillator disable bit is nonvolatile; zero runs, one stops.
// - Oscillator restarts about one second after being enabled.
// - Power-up with enabled oscillator silent for 5 ms sets fail flag.
// - On failure time reloads base time; control and calibration kept.
`timescale 1ns/1ps
`default_nettype none
`include "rtk_regs.vh"

module rtk_core #(
	parameter XTAL_PER_SEC  = `RTK_XTAL_HZ,
	parameter PWRUP_CYC     = `RTK_CLK_HZ / 1000000 * `RTK_PWRUP_WIN_US,
	parameter OSC_START_CYC = `RTK_CLK_HZ / 1000 * `RTK_OSC_START_MS,
	parameter XFER_CYC      = `RTK_XFER_CYC
) (
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       xtal_clk,
	input  wire       vcc_ok,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg        reg_rvalid,
	output reg        osc_running,
	output reg        on_backup,
	output reg        xfer_busy,
	output wire       oscillator_fail_flag
);

	// Implemented bits of a register; everything else reads zero
	function [7:0] bit_mask;
		input [3:0] a;
		begin
			if (a == `RTK_ADDR_FLAGS)
				bit_mask = `RTK_MASK_FLAGS;
			else if (a == `RTK_ADDR_CAL)
				bit_mask = `RTK_MASK_CAL;
			else if (a == `RTK_ADDR_SEC || a == `RTK_ADDR_MIN)
				bit_mask = `RTK_MASK_SEC;
			else if (a == `RTK_ADDR_HOUR || a == `RTK_ADDR_DATE)
				bit_mask = `RTK_MASK_HOUR;
			else if (a == `RTK_ADDR_DAY)
				bit_mask = `RTK_MASK_DAY;
			else if (a == `RTK_ADDR_MONTH)
				bit_mask = `RTK_MASK_MONTH;
			else
				bit_mask = `RTK_MASK_FULL;
		end
	endfunction

	// Time-bearing registers: century plus seconds through years
	function is_time;
		input [3:0] a;
		begin
			is_time = (a == `RTK_ADDR_CENTURY) || (a >= `RTK_ADDR_SEC);
		end
	endfunction

	reg  [7:0]  usr_r  [0:15];  // Host-visible buffer
	reg  [7:0]  run_r  [0:15];  // Running counters and live settings
	reg  [7:0]  base_r [0:15];  // Base time, kept across power loss
	reg         rd_frz_r;
	reg         wr_en_r;
	reg         oscillator_fail_flag_r;
	reg         xs1_r;
	reg         xs2_r;
	reg         xs3_r;
	reg         vs1_r;
	reg         vs2_r;
	reg         vs3_r;
	reg  [31:0] presc_r;
	reg  [31:0] start_r;
	reg  [31:0] chk_r;
	reg         chk_act_r;
	reg         seen_r;
	reg  [31:0] xfer_r;
	wire        xtal_rise;
	wire        pwr_rise;
	wire        osc_dis;
	wire        tick;
	wire        host_ok;
	wire [7:0]  n_sec;
	wire [7:0]  n_min;
	wire [7:0]  n_hour;
	wire [7:0]  n_day;
	wire [7:0]  n_date;
	wire [7:0]  n_month;
	wire [7:0]  n_year;
	wire [7:0]  n_cent;
	integer     i;

	// The second and third stages of each synchroniser feed the edge detectors
	assign xtal_rise = xs2_r & ~xs3_r;
	assign pwr_rise  = vs2_r & ~vs3_r;
	assign osc_dis   = run_r[`RTK_ADDR_CAL][`RTK_CAL_OSC_DIS];
	assign tick      = osc_running & xtal_rise &
		(presc_r == XTAL_PER_SEC - 1);
	// On backup power the host side is cut off, counting is not
	assign host_ok   = vs2_r;
	assign oscillator_fail_flag = oscillator_fail_flag_r;

	rtk_cal_inc u_cal (
		.cur_sec   (run_r[`RTK_ADDR_SEC]),
		.cur_min   (run_r[`RTK_ADDR_MIN]),
		.cur_hour  (run_r[`RTK_ADDR_HOUR]),
		.cur_day   (run_r[`RTK_ADDR_DAY]),
		.cur_date  (run_r[`RTK_ADDR_DATE]),
		.cur_month (run_r[`RTK_ADDR_MONTH]),
		.cur_year  (run_r[`RTK_ADDR_YEAR]),
		.cur_cent  (run_r[`RTK_ADDR_CENTURY]),
		.nxt_sec   (n_sec),
		.nxt_min   (n_min),
		.nxt_hour  (n_hour),
		.nxt_day   (n_day),
		.nxt_date  (n_date),
		.nxt_month (n_month),
		.nxt_year  (n_year),
		.nxt_cent  (n_cent)
	);

	// Pin synchronisers for the crystal and the supply monitor
	always @(posedge clk) begin
		if (sys_rst) begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
			vs1_r <= 1'b0;
			vs2_r <= 1'b0;
			vs3_r <= 1'b0;
		end else begin
			xs1_r <= xtal_clk;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
			vs1_r <= vcc_ok;
			vs2_r <= vs1_r;
			vs3_r <= vs2_r;
		end
	end

	// Oscillator start-up and one-second prescaler
	always @(posedge clk) begin
		if (sys_rst) begin
			osc_running <= 1'b0;
			start_r     <= 32'h00000000;
			presc_r     <= 32'h00000000;
		end else if (osc_dis) begin
			osc_running <= 1'b0;
			start_r     <= 32'h00000000;
			presc_r     <= 32'h00000000;
		end else if (!osc_running) begin
			// Restart delay models the crystal settling after enable
			if (start_r == OSC_START_CYC - 1)
				osc_running <= 1'b1;
			start_r <= start_r + 32'h00000001;
		end else if (xtal_rise) begin
			if (tick)
				presc_r <= 32'h00000000;
			else
				presc_r <= presc_r + 32'h00000001;
		end
	end

	// Oscillator check window, once after each supply rise
	always @(posedge clk) begin
		if (sys_rst) begin
			chk_act_r <= 1'b0;
			chk_r     <= 32'h00000000;
			seen_r    <= 1'b0;
		end else if (pwr_rise) begin
			chk_act_r <= 1'b1;
			chk_r     <= 32'h00000000;
			seen_r    <= 1'b0;
		end else if (chk_act_r) begin
			if (xtal_rise)
				seen_r <= 1'b1;
			if (chk_r == PWRUP_CYC - 1)
				chk_act_r <= 1'b0;
			chk_r <= chk_r + 32'h00000001;
		end
	end

	// Host accesses, buffers, counters and flags
	always @(posedge clk) begin
		if (sys_rst) begin
			for (i = 0; i < 16; i = i + 1) begin
				usr_r[i]  <= `RTK_RST_BYTE;
				run_r[i]  <= `RTK_RST_BYTE;
				base_r[i] <= `RTK_RST_BYTE;
			end
			usr_r[`RTK_ADDR_DAY]   <= `RTK_RST_DAY;
			usr_r[`RTK_ADDR_DATE]  <= `RTK_RST_DAY;
			usr_r[`RTK_ADDR_MONTH] <= `RTK_RST_DAY;
			run_r[`RTK_ADDR_DAY]   <= `RTK_RST_DAY;
			run_r[`RTK_ADDR_DATE]  <= `RTK_RST_DAY;
			run_r[`RTK_ADDR_MONTH] <= `RTK_RST_DAY;
			rd_frz_r   <= 1'b0;
			wr_en_r    <= 1'b0;
			oscillator_fail_flag_r     <= 1'b0;
			xfer_busy  <= 1'b0;
			xfer_r     <= 32'h00000000;
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
			on_backup  <= 1'b0;
		end else begin
			on_backup  <= ~vs2_r;
			reg_rvalid <= 1'b0;

			// Counters advance each second whatever the host does
			if (tick) begin
				run_r[`RTK_ADDR_SEC]     <= n_sec;
				run_r[`RTK_ADDR_MIN]     <= n_min;
				run_r[`RTK_ADDR_HOUR]    <= n_hour;
				run_r[`RTK_ADDR_DAY]     <= n_day;
				run_r[`RTK_ADDR_DATE]    <= n_date;
				run_r[`RTK_ADDR_MONTH]   <= n_month;
				run_r[`RTK_ADDR_YEAR]    <= n_year;
				run_r[`RTK_ADDR_CENTURY] <= n_cent;
			end

			// Refresh the buffer unless frozen; all fields move together
			if (!rd_frz_r && !wr_en_r && !xfer_busy) begin
				for (i = 0; i < 16; i = i + 1)
					if (is_time(i[3:0]))
						usr_r[i] <= run_r[i];
			end

			// Host read: data registered, reserved bits zero
			if (reg_rd && host_ok) begin
				reg_rvalid <= 1'b1;
				rd_frz_r   <= 1'b1;
				if (reg_addr == `RTK_ADDR_FLAGS)
					reg_rdata <= {oscillator_fail_flag_r, 5'h00, wr_en_r, rd_frz_r};
				else
					reg_rdata <= usr_r[reg_addr] & bit_mask(reg_addr);
			end

			// Host write
			if (reg_wr && host_ok) begin
				if (reg_addr == `RTK_ADDR_FLAGS) begin
					rd_frz_r <= reg_wdata[`RTK_FLAG_READ];
					wr_en_r  <= reg_wdata[`RTK_FLAG_WRITE];
					if (wr_en_r && !reg_wdata[`RTK_FLAG_OSCILLATOR_FAIL_FLAG])
						oscillator_fail_flag_r <= 1'b0;
					// Falling write bit starts the transfer to counters
					if (wr_en_r && !reg_wdata[`RTK_FLAG_WRITE]) begin
						xfer_busy <= 1'b1;
						xfer_r    <= 32'h00000000;
					end
				end else if (wr_en_r) begin
					// Stored as written less reserved bits, so bad BCD counts on as is
					usr_r[reg_addr] <= reg_wdata & bit_mask(reg_addr);
				end
			end

			// Transfer after the fixed transfer time
			if (xfer_busy) begin
				xfer_r <= xfer_r + 32'h00000001;
				if (xfer_r == XFER_CYC - 1) begin
					xfer_busy <= 1'b0;
					for (i = 1; i < 16; i = i + 1) begin
						run_r[i] <= usr_r[i];
						if (is_time(i[3:0]))
							base_r[i] <= usr_r[i];
					end
				end
			end

			// Oscillator failure: reload base time, settings untouched
			if (chk_act_r && chk_r == PWRUP_CYC - 1 &&
				!osc_dis && !seen_r && !xtal_rise) begin
				oscillator_fail_flag_r <= 1'b1;
				for (i = 0; i < 16; i = i + 1)
					if (is_time(i[3:0])) begin
						run_r[i] <= base_r[i];
						usr_r[i] <= base_r[i];
					end
			end
		end
	end

endmodule

`default_nettype wire

// [hw/rtk_regs.vh]
// Register map, field positions and timing constants of the timekeeping core
`ifndef RTK_REGS_VH
`define RTK_REGS_VH

// Clock register addresses
`define RTK_ADDR_FLAGS    4'h0
`define RTK_ADDR_CENTURY  4'h6
`define RTK_ADDR_CAL      4'h8
`define RTK_ADDR_SEC      4'h9
`define RTK_ADDR_MIN      4'hA
`define RTK_ADDR_HOUR     4'hB
`define RTK_ADDR_DAY      4'hC
`define RTK_ADDR_DATE     4'hD
`define RTK_ADDR_MONTH    4'hE
`define RTK_ADDR_YEAR     4'hF

// Flags register fields
`define RTK_FLAG_READ     0
`define RTK_FLAG_WRITE    1
`define RTK_FLAG_OSCILLATOR_FAIL_FLAG     7
// Calibration register: oscillator disable bit
`define RTK_CAL_OSC_DIS   7

// Implemented bits per register, reserved bits read zero
`define RTK_MASK_FLAGS    8'h83
`define RTK_MASK_CAL      8'hBF
`define RTK_MASK_SEC      8'h7F
`define RTK_MASK_MIN      8'h7F
`define RTK_MASK_HOUR     8'h3F
`define RTK_MASK_DAY      8'h07
`define RTK_MASK_DATE     8'h3F
`define RTK_MASK_MONTH    8'h1F
`define RTK_MASK_FULL     8'hFF

// Reset values
`define RTK_RST_BYTE      8'h00
`define RTK_RST_DAY       8'h01

// Timing
`define RTK_CLK_HZ        10000000
`define RTK_XTAL_HZ       32768
`define RTK_PWRUP_WIN_US  5000
`define RTK_OSC_START_MS  1000
`define RTK_XFER_CYC      16

`endif

// [hw/rtk_cal_inc.v]
// One-second calendar step on BCD time, date and day fields
`timescale 1ns/1ps
`default_nettype none

module rtk_cal_inc (
	input  wire [7:0] cur_sec,
	input  wire [7:0] cur_min,
	input  wire [7:0] cur_hour,
	input  wire [7:0] cur_day,
	input  wire [7:0] cur_date,
	input  wire [7:0] cur_month,
	input  wire [7:0] cur_year,
	input  wire [7:0] cur_cent,
	output reg  [7:0] nxt_sec,
	output reg  [7:0] nxt_min,
	output reg  [7:0] nxt_hour,
	output reg  [7:0] nxt_day,
	output reg  [7:0] nxt_date,
	output reg  [7:0] nxt_month,
	output reg  [7:0] nxt_year,
	output reg  [7:0] nxt_cent
);

	// BCD step; a bad nibble runs on to F and wraps to 0
	function [8:0] bcd_inc;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] hi;
		begin
			if (v == hi)
				bcd_inc = {1'b1, lo};
			else if (v[3:0] == 4'h9 || v[3:0] == 4'hF)
				bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Two BCD digits divisible by four
	function div4;
		input [7:0] v;
		begin
			if (v[4] == 1'b0)
				div4 = (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
			else
				div4 = (v[3:0] == 4'h2 || v[3:0] == 4'h6);
		end
	endfunction

	reg       c_sec;
	reg       c_min;
	reg       c_hour;
	reg       c_date;
	reg       c_month;
	reg       c_year;
	reg       leap;
	reg [7:0] last_date;
	reg [8:0] day_step;
	reg [8:0] cent_step;

	// Ripple of carries from seconds up to century
	always @* begin
		nxt_min   = cur_min;
		nxt_hour  = cur_hour;
		nxt_day   = cur_day;
		nxt_date  = cur_date;
		nxt_month = cur_month;
		nxt_year  = cur_year;
		nxt_cent  = cur_cent;
		c_min     = 1'b0;
		c_hour    = 1'b0;
		c_date    = 1'b0;
		c_month   = 1'b0;
		c_year    = 1'b0;
		// Day and century wrap on their own; their carry goes nowhere
		day_step  = bcd_inc(cur_day, 8'h01, 8'h07);
		cent_step = bcd_inc(cur_cent, 8'h00, 8'h99);
		// Century years are leap only when the century divides by four
		leap = (cur_year == 8'h00) ? div4(cur_cent) : div4(cur_year);
		if (cur_month == 8'h02)
			last_date = leap ? 8'h29 : 8'h28;
		else if (cur_month == 8'h04 || cur_month == 8'h06 ||
			cur_month == 8'h09 || cur_month == 8'h11)
			last_date = 8'h30;
		else
			last_date = 8'h31;
		{c_sec, nxt_sec} = bcd_inc(cur_sec, 8'h00, 8'h59);
		if (c_sec)
			{c_min, nxt_min} = bcd_inc(cur_min, 8'h00, 8'h59);
		if (c_min)
			{c_hour, nxt_hour} = bcd_inc(cur_hour, 8'h00, 8'h23);
		if (c_hour) begin
			nxt_day = day_step[7:0];
			{c_date, nxt_date} = bcd_inc(cur_date, 8'h01, last_date);
		end
		if (c_date)
			{c_month, nxt_month} = bcd_inc(cur_month, 8'h01, 8'h12);
		if (c_month)
			{c_year, nxt_year} = bcd_inc(cur_year, 8'h00, 8'h99);
		if (c_year)
			nxt_cent = cent_step[7:0];
	end

endmodule

`default_nettype wire

// [tb/rtk_xtal_model.sv]
// Crystal oscillator model that drives the crystal clock pin
`timescale 1ns/1ps
`default_nettype none

module rtk_xtal_model (
	input  wire logic run,
	output var  logic xtal
);
	// Stands still low while stopped, so a silent crystal shows no edges
	initial xtal = 1'b0;

	// Full periods only, so the edge count seen by the core stays exact
	always begin
		wait (run);
		#400 xtal = 1'b1;
		#400 xtal = 1'b0;
	end
endmodule

`default_nettype wire

// [tb/rtk_core_checker.sv]
// Port checker for the timekeeping core
`timescale 1ns/1ps
`default_nettype none
`include "rtk_regs.vh"

module rtk_core_checker #(
	parameter XFER_CYC = `RTK_XFER_CYC
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       vcc_ok,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       osc_running,
	input wire logic       on_backup,
	input wire logic       xfer_busy,
	input wire logic       oscillator_fail_flag
);
	logic [7:0] busy_cnt_r;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Implemented bits of each register; everything else must read zero
	function automatic logic [7:0] msk(input logic [3:0] a);
		case (a)
			`RTK_ADDR_FLAGS: msk = `RTK_MASK_FLAGS;
			`RTK_ADDR_CAL:   msk = `RTK_MASK_CAL;
			`RTK_ADDR_SEC, `RTK_ADDR_MIN: msk = `RTK_MASK_SEC;
			`RTK_ADDR_HOUR, `RTK_ADDR_DATE: msk = `RTK_MASK_HOUR;
			`RTK_ADDR_DAY:   msk = `RTK_MASK_DAY;
			`RTK_ADDR_MONTH: msk = `RTK_MASK_MONTH;
			default:         msk = `RTK_MASK_FULL;
		endcase
	endfunction

	// Length of the pending transfer, cleared whenever it is idle
	always @(posedge clk) begin
		if (sys_rst || !xfer_busy)
			busy_cnt_r <= 8'h00;
		else
			busy_cnt_r <= busy_cnt_r + 8'h01;
	end

	sequence s_supply_up;
		vcc_ok && $past(vcc_ok) && $past(vcc_ok, 2) && $past(vcc_ok, 3);
	endsequence
	sequence s_osc_wait;
		$fell(sys_rst) ##0 (!osc_running) [*4];
	endsequence

	a_rd_answer: assert property (reg_rd ##0 s_supply_up |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read data without a read");
	a_reserved_zero: assert property (reg_rvalid |->
		(reg_rdata & ~msk($past(reg_addr))) == 8'h00)
		else $error("reserved bits not zero");
	a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved between reads");
	a_busy_len: assert property ($fell(xfer_busy) |->
		$past(busy_cnt_r) == XFER_CYC - 1)
		else $error("transfer time wrong");
	a_busy_cause: assert property ($rose(xfer_busy) |->
		$past(reg_wr && reg_addr == 4'h0 && !reg_wdata[1]))
		else $error("transfer without clearing write bit");
	a_fail_clear: assert property ($fell(oscillator_fail_flag) &&
		!$past(sys_rst) |->
		$past(reg_wr && reg_addr == 4'h0 && !reg_wdata[7]))
		else $error("fail flag dropped on its own");
	a_backup_follow: assert property ((!vcc_ok) [*4] |-> on_backup)
		else $error("backup not flagged");
	a_osc_start: assert property (s_osc_wait |-> ##[1:8] osc_running)
		else $error("oscillator start time wrong");
endmodule

bind rtk_core rtk_core_checker #(.XFER_CYC(XFER_CYC)) u_chk (
	.clk                  (clk),
	.sys_rst              (sys_rst),
	.vcc_ok               (vcc_ok),
	.reg_wr               (reg_wr),
	.reg_rd               (reg_rd),
	.reg_addr             (reg_addr),
	.reg_wdata            (reg_wdata),
	.reg_rdata            (reg_rdata),
	.reg_rvalid           (reg_rvalid),
	.osc_running          (osc_running),
	.on_backup            (on_backup),
	.xfer_busy            (xfer_busy),
	.oscillator_fail_flag (oscillator_fail_flag)
);

`default_nettype wire

// [tb/test_rtk_core.sv]
// Self-checking testbench for the timekeeping core
`timescale 1ns/1ps
`default_nettype none

module test_rtk_core;
	logic       clk, sys_rst, xtal_en, xtal_clk, vcc_ok;
	logic       reg_wr, reg_rd, reg_rvalid, xfer_busy;
	logic       osc_running, on_backup, oscillator_fail_flag;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	int         n_mismatch, tests_run;

	// Short counts keep a one-second tick at four crystal edges
	rtk_core #(.XTAL_PER_SEC(4), .PWRUP_CYC(20), .OSC_START_CYC(8)) DUT (
		.clk(clk), .sys_rst(sys_rst), .xtal_clk(xtal_clk),
		.vcc_ok(vcc_ok), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.osc_running(osc_running), .on_backup(on_backup),
		.xfer_busy(xfer_busy),
		.oscillator_fail_flag(oscillator_fail_flag));
	rtk_xtal_model XTAL (.run(xtal_en), .xtal(xtal_clk));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task close_out;
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Inputs move one nanosecond after the edge
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		cyc(1);
		reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		cyc(1);
		reg_wr = 1'b0;
	endtask
	// Read data stays on the port until the next read
	task rd(input logic [3:0] a, input logic v);
		cyc(1);
		reg_rd = 1'b1; reg_addr = a;
		cyc(1);
		reg_rd = 1'b0;
		chk({7'h00, reg_rvalid}, {7'h00, v});
	endtask
	// Exactly n crystal periods, then room for sync and tick
	task xt(input int n);
		xtal_en = 1'b1;
		#(800 * n - 100);
		xtal_en = 1'b0;
		cyc(6);
	endtask
	// Order: sec, min, hour, day, date, month, year, century
	function automatic logic [3:0] adr(input int i);
		return (i == 7) ? 4'h6 : 4'(9 + i);
	endfunction
	task put(input logic [7:0] t [8]);
		wr(4'h0, 8'h02);
		wr(4'h0, 8'h02);
		for (int i = 0; i < 8; i++) wr(adr(i), t[i]);
		wr(4'h0, 8'h00);
		chk({7'h00, xfer_busy}, 8'h01);
		cyc(20);
		chk({7'h00, xfer_busy}, 8'h00);
	endtask
	task rdall(input logic [7:0] t [8]);
		for (int i = 0; i < 8; i++) begin
			rd(adr(i), 1'b1);
			chk(reg_rdata, t[i]);
		end
	endtask

	initial begin
		sys_rst = 1'b1; xtal_en = 1'b0; vcc_ok = 1'b0;
		reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
		n_mismatch = 0; tests_run = 0;
		cyc(2);
		sys_rst = 1'b0;
		vcc_ok = 1'b1;
		cyc(12);
		chk({7'h00, osc_running}, 8'h01);
		// Crystal silent through the power-up window
		cyc(20);
		chk({7'h00, oscillator_fail_flag}, 8'h01);
		rd(4'h0, 1'b1);
		chk(reg_rdata & 8'hFC, 8'h80);
		// Rollover of seconds through year, with carry of the century from 19 to 20, in one tick
		put('{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h19});
		chk({7'h00, oscillator_fail_flag}, 8'h00);
		xt(4);
		wr(4'h0, 8'h01);
		rdall('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h20});
		// Frozen copy ignores a tick until the read bit is cleared
		xt(4);
		rd(4'h9, 1'b1);
		chk(reg_rdata, 8'h00);
		wr(4'h0, 8'h00);
		cyc(3);
		rd(4'h9, 1'b1);
		chk(reg_rdata, 8'h01);
		// Invalid digit F wraps to 0 with carry into the tens
		put('{8'h0F, 8'h00, 8'h10, 8'h03, 8'h15, 8'h06, 8'h24, 8'h20});
		xt(4);
		rd(4'h9, 1'b1);
		chk(reg_rdata, 8'h10);
		wr(4'h9, 8'h33);
		rd(4'h9, 1'b1);
		chk(reg_rdata, 8'h10);
		// Supply loss, then a power-up with a dead crystal
		vcc_ok = 1'b0;
		cyc(5);
		chk({7'h00, on_backup}, 8'h01);
		rd(4'h9, 1'b0);
		vcc_ok = 1'b1;
		cyc(30);
		chk({6'h00, on_backup, oscillator_fail_flag}, 8'h01);
		wr(4'h0, 8'h00);
		cyc(3);
		rd(4'h9, 1'b1);
		chk(reg_rdata, 8'h0F);
		rd(4'hB, 1'b1);
		chk(reg_rdata, 8'h10);
		close_out;
	end
endmodule

`default_nettype wire
